// *** rtl/senr_evt_fmt.sv ***
`timescale 1ns/1ps
// builds one event record and holds it until the controller takes it
module senr_evt_fmt (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic start,
	input wire senr_pkg::senr_kind_t kind,
	input wire logic [7:0] loc_a,
	input wire logic [7:0] loc_b,
	input wire senr_pkg::senr_origin_t origin,
	input wire logic ready,
	output logic valid,
	output logic busy,
	output logic [7:0] sensor_type,
	output logic [7:0] sensor_num,
	output logic [7:0] type_code,
	output logic [7:0] data1,
	output logic [7:0] data2,
	output logic [7:0] data3,
	output logic [7:0] sw_id
);
	import senr_pkg::*;

	typedef struct packed {
		senr_fmt_state_t st;
		logic [7:0] stype;
		logic [7:0] d1;
		logic [7:0] d2;
		logic [7:0] d3;
		logic [7:0] swid;
	} senr_fmt_st_t;

	senr_fmt_st_t s_r;
	senr_fmt_st_t s_nxt;

	// first data byte for discrete bus events
	function automatic logic [7:0] bus_d1(input logic [3:0] ofs, input logic loc3);
		bus_d1 = {1'b0, (loc3 ? LOC3_USED : LOC3_NONE), 1'b0, ofs};
	endfunction

	function automatic logic [7:0] origin_code(input senr_origin_t o);
		case (o)
			ORG_POST: origin_code = SWID_POST;
			ORG_SMM: origin_code = SWID_SMM;
			ORG_ADDON: origin_code = SWID_ADDON;
			default: origin_code = SWID_ADDON_SMM;
		endcase
	endfunction

	// record assembly and hold until taken
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			FMT_IDLE: begin
				if (start) begin
					s_nxt.st = FMT_HOLD;
					s_nxt.swid = origin_code(origin);
					s_nxt.d2 = loc_a;
					s_nxt.d3 = DATA_UNUSED;
					s_nxt.stype = SENSOR_BUS;
					case (kind)
						K_SBE: begin
							s_nxt.stype = SENSOR_MEM;
							s_nxt.d1 = D1_SBE;
						end
						K_MBE: begin
							s_nxt.stype = SENSOR_MEM;
							s_nxt.d1 = D1_MBE;
						end
						K_MPAR: begin
							s_nxt.stype = SENSOR_MEM;
							s_nxt.d1 = bus_d1(OFS_PARITY, 1'b0);
							s_nxt.d2 = DATA_UNUSED;
						end
						K_IO_CHANNEL_CHECK_N: s_nxt.d1 = bus_d1(OFS_PARITY, 1'b0);
						K_PERR: begin
							s_nxt.d1 = bus_d1(OFS_PERR, 1'b1);
							s_nxt.d3 = loc_b;
						end
						default: begin
							s_nxt.d1 = bus_d1(OFS_SERR, 1'b1);
							s_nxt.d3 = loc_b;
						end
					endcase
				end
			end
			FMT_HOLD: begin
				if (ready) begin
					s_nxt.st = FMT_IDLE;
				end
			end
			default: s_nxt.st = FMT_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the held record, except sensor number and type code, which are constants
	assign valid = (s_r.st == FMT_HOLD);
	assign busy = (s_r.st == FMT_HOLD);
	assign sensor_type = s_r.stype;
	assign sensor_num = SENSOR_NUM_NA;
	assign type_code = TYPE_CODE;
	assign data1 = s_r.d1;
	assign data2 = s_r.d2;
	assign data3 = s_r.d3;
	assign sw_id = s_r.swid;
endmodule

// *** rtl/senr_pkg.sv ***
// Behaviour
// - port 61h bit 7 reads parity pending
// - port 61h bit 6 reads channel check
// - port 61h bit 3 enables channel check
// - port 61h bit 2 enables parity check
// - port 70h bit 7 masks NMI
// - enabled ISA errors raise NMI
// - SMI disabled routes bus errors to NMI
// - SMI disabled means no SMI ever
// - SMI enabled takes every error first; here a PERR without SERR raises neither SMI nor NMI
// - bridge forwards secondary SERR and PERR upstream
// - 04h bit 6 and 05h bit 1 gate; forwarded secondary SERR/PERR here need only FORWARD_ENABLE
// - 90h bit 4 SERR on target abort
// - 90h bit 3 SERR on parity
// - 90h bit 1 SERR on multi-bit
// - location byte two holds device and function
// - location byte one holds bus number
// - first data byte flags, offset layout
// - third data byte FFh when unused
// - software origin identifier codes
// - memory records 0C, E7, 20/21, module, FF
// - ISA record slot byte, 0ffh unknown
// - 90h bit 0 SERR on single-bit
// - 91h status flags and failing rows
package senr_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [15:0] IO_SYSCTL = 16'h0061;
	localparam logic [15:0] IO_NMI_MASK = 16'h0070;
	localparam logic [7:0] CFG_PARITY_EN = 8'h04;
	localparam logic [7:0] CFG_SERR_EN = 8'h05;
	localparam logic [7:0] CFG_ERR_CMD = 8'h90;
	localparam logic [7:0] CFG_MEM_STAT = 8'h91;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int SC_PAR_FLAG = 7;
	localparam int SC_CHK_FLAG = 6;
	localparam int SC_CHK_EN = 3;
	localparam int SC_PAR_EN = 2;
	localparam int NMI_MASK_BIT = 7;
	localparam int PERR_EN_BIT = 6;
	localparam int SERR_EN_BIT = 1;
	localparam int EC_TA = 4;
	localparam int EC_PCI_PAR = 3;
	localparam int EC_MBE = 1;
	localparam int EC_SBE = 0;
	localparam int MS_MBE_FLAG = 4;
	localparam int MS_MBE_ROW = 5;
	localparam int MS_SBE_FLAG = 0;
	localparam int MS_SBE_ROW = 1;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************************************
	// event record encodings
	// ****************************************
	localparam logic [7:0] SENSOR_MEM = 8'h0C;
	localparam logic [7:0] SENSOR_BUS = 8'h13;
	localparam logic [7:0] SENSOR_NUM_NA = 8'hEF;
	localparam logic [7:0] TYPE_CODE = 8'hE7;
	localparam logic [7:0] D1_SBE = 8'h20;
	localparam logic [7:0] D1_MBE = 8'h21;
	localparam logic [3:0] OFS_PARITY = 4'h2;
	localparam logic [3:0] OFS_PERR = 4'h4;
	localparam logic [3:0] OFS_SERR = 4'h5;
	localparam logic [1:0] LOC3_NONE = 2'b00;
	localparam logic [1:0] LOC3_USED = 2'b10;
	localparam logic [7:0] DATA_UNUSED = 8'hFF;
	localparam logic [7:0] SWID_POST = 8'h00;
	localparam logic [7:0] SWID_SMM = 8'h10;
	localparam logic [7:0] SWID_ADDON = 8'h01;
	localparam logic [7:0] SWID_ADDON_SMM = 8'h11;
	localparam int NUM_KINDS = 6;

	// event kinds, lower code wins when several are pending
	typedef enum logic [2:0] {
		K_SBE = 3'b000,
		K_MBE = 3'b001,
		K_MPAR = 3'b010,
		K_IO_CHANNEL_CHECK_N = 3'b011,
		K_PERR = 3'b100,
		K_SERR = 3'b101
	} senr_kind_t;

	typedef enum logic [1:0] {
		ORG_POST = 2'b00,
		ORG_SMM = 2'b01,
		ORG_ADDON = 2'b10,
		ORG_ADDON_SMM = 2'b11
	} senr_origin_t;

	typedef enum logic {
		FMT_IDLE = 1'b0,
		FMT_HOLD = 1'b1
	} senr_fmt_state_t;

endpackage

// *** rtl/senr_top.sv ***
`timescale 1ns/1ps
// error gating, NMI/SMI routing, bridge SERR/PERR and event record issue
module senr_top (
	input wire logic CLK,
	input wire logic RESET_N,
	// legacy I/O port access
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA,
	// host bridge configuration access
	input wire logic [7:0] CFG_ADDR,
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [7:0] CFG_WDATA,
	output logic [7:0] CFG_RDATA,
	// error sources
	input wire logic IO_CHANNEL_CHECK_N,
	input wire logic ISA_MEM_PARITY_ERR,
	input wire logic [7:0] ISA_SLOT,
	input wire logic SINGLE_BIT_ERROR,
	input wire logic MULTI_BIT_ERROR,
	input wire logic [2:0] ECC_ROW,
	input wire logic [7:0] ECC_DIMM,
	input wire logic TARGET_ABORT,
	input wire logic PCI_PARITY_ERR,
	input wire logic [7:0] PCI_ERR_BUS,
	input wire logic [7:0] PCI_ERR_DEVFN,
	input wire logic SEC_SERR_N,
	input wire logic SEC_PERR_N,
	input wire logic FORWARD_ENABLE,
	input wire logic SMI_ENABLE,
	input wire senr_pkg::senr_origin_t EVT_ORIGIN,
	// processor interrupts
	output logic NMI,
	output logic SMI,
	// primary side open-drain error pins
	output logic PRI_SERR_N_O,
	output logic PRI_SERR_OE_N,
	output logic PRI_PERR_N_O,
	output logic PRI_PERR_OE_N,
	// event record toward the management controller
	output logic EVT_VALID,
	input wire logic EVT_READY,
	output logic [7:0] EVT_SENSOR_TYPE,
	output logic [7:0] EVT_SENSOR_NUM,
	output logic [7:0] EVT_TYPE_CODE,
	output logic [7:0] EVT_DATA1,
	output logic [7:0] EVT_DATA2,
	output logic [7:0] EVT_DATA3,
	output logic [7:0] EVT_SW_ID
);
	import senr_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic par_en;
		logic chk_en;
		logic par_flag;
		logic chk_flag;
		logic nmi_mask;
		logic [7:0] parity_report_en;
		logic [7:0] system_error_en;
		logic [7:0] err_cmd;
		logic [7:0] mem_stat;
		logic serr_pend;
		logic pri_serr;
		logic pri_perr;
		logic nmi;
		logic smi;
		logic [NUM_KINDS-1:0] pend;
		logic [7:0] mem_loc;
		logic [7:0] slot_loc;
		logic [7:0] pci_bus;
		logic [7:0] pci_devfn;
		logic [7:0] io_rdata;
		logic [7:0] cfg_rdata;
	} senr_top_st_t;

	senr_top_st_t s_r;
	senr_top_st_t s_nxt;

	logic fmt_busy;
	logic fmt_start;
	senr_kind_t fmt_kind;
	logic [7:0] fmt_loc_a;
	logic [7:0] fmt_loc_b;

	// lowest pending kind wins
	function automatic senr_kind_t first_kind(input logic [NUM_KINDS-1:0] p);
		first_kind = K_SERR;
		for (int i = NUM_KINDS - 1; i >= 0; i--) begin
			if (p[i]) begin
				first_kind = senr_kind_t'(i[2:0]);
			end
		end
	endfunction

	// one-hot bit of an event kind
	function automatic logic [NUM_KINDS-1:0] kind_bit(input senr_kind_t k);
		kind_bit = '0;
		kind_bit[k] = 1'b1;
	endfunction

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		logic io_sc_wr;
		logic io_mask_wr;
		logic chk_seen;
		logic par_seen;
		logic serr_evt;
		logic fwd_serr;
		logic perr_evt;
		logic err_any;
		logic [NUM_KINDS-1:0] new_evt;
		logic [NUM_KINDS-1:0] pend_clr;
		io_sc_wr = 1'b0;
		io_mask_wr = 1'b0;
		chk_seen = 1'b0;
		par_seen = 1'b0;
		serr_evt = 1'b0;
		fwd_serr = 1'b0;
		perr_evt = 1'b0;
		err_any = 1'b0;
		new_evt = '0;
		pend_clr = '0;
		s_nxt = s_r;

		io_sc_wr = IO_WR && (IO_ADDR == IO_SYSCTL);
		io_mask_wr = IO_WR && (IO_ADDR == IO_NMI_MASK);

		// port 61h enables; flag bits and reserved bits ignore writes
		if (io_sc_wr) begin
			s_nxt.chk_en = IO_WDATA[SC_CHK_EN];
			s_nxt.par_en = IO_WDATA[SC_PAR_EN];
		end
		// NMI mask held until software clears it
		if (io_mask_wr) begin
			s_nxt.nmi_mask = IO_WDATA[NMI_MASK_BIT];
		end

		// ISA flags: writing the enable low clears, a new error wins
		chk_seen = !IO_CHANNEL_CHECK_N;
		par_seen = ISA_MEM_PARITY_ERR;
		if (io_sc_wr && !IO_WDATA[SC_CHK_EN]) begin
			s_nxt.chk_flag = 1'b0;
		end
		if (io_sc_wr && !IO_WDATA[SC_PAR_EN]) begin
			s_nxt.par_flag = 1'b0;
		end
		if (chk_seen) begin
			s_nxt.chk_flag = 1'b1;
		end
		if (par_seen) begin
			s_nxt.par_flag = 1'b1;
		end

		// host bridge configuration writes
		if (CFG_WR) begin
			case (CFG_ADDR)
				CFG_PARITY_EN: s_nxt.parity_report_en = CFG_WDATA;
				CFG_SERR_EN: s_nxt.system_error_en = CFG_WDATA;
				CFG_ERR_CMD: s_nxt.err_cmd = CFG_WDATA;
				CFG_MEM_STAT: begin
					// write one to a flag clears it
					if (CFG_WDATA[MS_MBE_FLAG]) begin
						s_nxt.mem_stat[MS_MBE_FLAG] = 1'b0;
					end
					if (CFG_WDATA[MS_SBE_FLAG]) begin
						s_nxt.mem_stat[MS_SBE_FLAG] = 1'b0;
					end
				end
				default: s_nxt.cfg_rdata = s_nxt.cfg_rdata;
			endcase
		end

		// memory error status with failing rows, set wins over clear
		if (MULTI_BIT_ERROR) begin
			s_nxt.mem_stat[MS_MBE_FLAG] = 1'b1;
			s_nxt.mem_stat[MS_MBE_ROW +: 3] = ECC_ROW;
		end
		if (SINGLE_BIT_ERROR) begin
			s_nxt.mem_stat[MS_SBE_FLAG] = 1'b1;
			s_nxt.mem_stat[MS_SBE_ROW +: 3] = ECC_ROW;
		end

		// host bridge SERR sources behind the SERR enable; forwarded secondary SERR only behind FORWARD_ENABLE
		serr_evt = s_r.system_error_en[SERR_EN_BIT] && (
			(TARGET_ABORT && s_r.err_cmd[EC_TA]) ||
			(PCI_PARITY_ERR && s_r.err_cmd[EC_PCI_PAR]) ||
			(MULTI_BIT_ERROR && s_r.err_cmd[EC_MBE]) ||
			(SINGLE_BIT_ERROR && s_r.err_cmd[EC_SBE]));
		fwd_serr = FORWARD_ENABLE && !SEC_SERR_N;
		perr_evt = (PCI_PARITY_ERR && s_r.parity_report_en[PERR_EN_BIT]) ||
			(FORWARD_ENABLE && !SEC_PERR_N);
		s_nxt.pri_serr = serr_evt || fwd_serr;
		s_nxt.pri_perr = perr_evt;

		// SERR pending for the interrupt path, dropped by clearing the enable
		if (CFG_WR && (CFG_ADDR == CFG_SERR_EN) && !CFG_WDATA[SERR_EN_BIT]) begin
			s_nxt.serr_pend = 1'b0;
		end
		if (serr_evt || fwd_serr) begin
			s_nxt.serr_pend = 1'b1;
		end

		// route enabled ISA errors and pending SERR to SMI when enabled, else to NMI
		err_any = (s_r.par_flag && s_r.par_en) || (s_r.chk_flag && s_r.chk_en) || s_r.serr_pend;
		s_nxt.smi = err_any && SMI_ENABLE;
		s_nxt.nmi = err_any && !SMI_ENABLE && !s_r.nmi_mask;

		// event capture with location bytes
		new_evt[K_SBE] = SINGLE_BIT_ERROR;
		new_evt[K_MBE] = MULTI_BIT_ERROR;
		new_evt[K_MPAR] = par_seen && s_r.par_en;
		new_evt[K_IO_CHANNEL_CHECK_N] = chk_seen && !s_r.chk_flag && s_r.chk_en;
		new_evt[K_PERR] = perr_evt;
		new_evt[K_SERR] = serr_evt || fwd_serr;
		if (SINGLE_BIT_ERROR || MULTI_BIT_ERROR) begin
			s_nxt.mem_loc = ECC_DIMM;
		end
		if (new_evt[K_IO_CHANNEL_CHECK_N]) begin
			s_nxt.slot_loc = ISA_SLOT;
		end
		if (new_evt[K_PERR] || new_evt[K_SERR]) begin
			s_nxt.pci_bus = PCI_ERR_BUS;
			s_nxt.pci_devfn = PCI_ERR_DEVFN;
		end
		if (fmt_start) begin
			pend_clr = kind_bit(fmt_kind);
		end
		s_nxt.pend = (s_r.pend & ~pend_clr) | new_evt;

		// registered read data; reserved and unmapped read zero
		if (IO_RD) begin
			s_nxt.io_rdata = REG_RESET;
			if (IO_ADDR == IO_SYSCTL) begin
				s_nxt.io_rdata[SC_PAR_FLAG] = s_r.par_flag;
				s_nxt.io_rdata[SC_CHK_FLAG] = s_r.chk_flag;
				s_nxt.io_rdata[SC_CHK_EN] = s_r.chk_en;
				s_nxt.io_rdata[SC_PAR_EN] = s_r.par_en;
			end
		end
		if (CFG_RD) begin
			case (CFG_ADDR)
				CFG_PARITY_EN: s_nxt.cfg_rdata = s_r.parity_report_en;
				CFG_SERR_EN: s_nxt.cfg_rdata = s_r.system_error_en;
				CFG_ERR_CMD: s_nxt.cfg_rdata = s_r.err_cmd;
				CFG_MEM_STAT: s_nxt.cfg_rdata = s_r.mem_stat;
				default: s_nxt.cfg_rdata = REG_RESET;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// event record issue
	// ****************************************
	// start the formatter on the lowest pending kind when it is free
	always_comb begin
		fmt_start = !fmt_busy && (|s_r.pend);
		fmt_kind = first_kind(s_r.pend);
		fmt_loc_b = DATA_UNUSED;
		case (fmt_kind)
			K_SBE, K_MBE: fmt_loc_a = s_r.mem_loc;
			K_IO_CHANNEL_CHECK_N: fmt_loc_a = s_r.slot_loc;
			K_PERR, K_SERR: begin
				fmt_loc_a = s_r.pci_bus;
				fmt_loc_b = s_r.pci_devfn;
			end
			default: fmt_loc_a = DATA_UNUSED;
		endcase
	end

	senr_evt_fmt u_fmt (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.start(fmt_start),
		.kind(fmt_kind),
		.loc_a(fmt_loc_a),
		.loc_b(fmt_loc_b),
		.origin(EVT_ORIGIN),
		.ready(EVT_READY),
		.valid(EVT_VALID),
		.busy(fmt_busy),
		.sensor_type(EVT_SENSOR_TYPE),
		.sensor_num(EVT_SENSOR_NUM),
		.type_code(EVT_TYPE_CODE),
		.data1(EVT_DATA1),
		.data2(EVT_DATA2),
		.data3(EVT_DATA3),
		.sw_id(EVT_SW_ID)
	);

	// ****************************************
	// outputs
	// ****************************************
	// open-drain pins only ever pull low
	assign PRI_SERR_N_O = 1'b0;
	assign PRI_SERR_OE_N = !s_r.pri_serr;
	assign PRI_PERR_N_O = 1'b0;
	assign PRI_PERR_OE_N = !s_r.pri_perr;
	assign NMI = s_r.nmi;
	assign SMI = s_r.smi;
	assign IO_RDATA = s_r.io_rdata;
	assign CFG_RDATA = s_r.cfg_rdata;
endmodule

// *** tb/senr_mgmt_model.sv ***
`timescale 1ns/1ps
// management controller: takes each record after a chosen stall
module senr_mgmt_model (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [3:0] stall,
	input wire logic evt_valid,
	input wire logic [55:0] evt_rec,
	output logic evt_ready,
	output logic [55:0] got_rec,
	output logic [7:0] got_cnt
);
	logic [3:0] wait_r;
	// ready is raised after the stall and dropped at the taking edge
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{evt_ready, wait_r, got_rec, got_cnt} <= '0;
		end else if (evt_valid && evt_ready) begin
			evt_ready <= 1'b0;
			wait_r <= 4'h0;
			got_rec <= evt_rec;
			got_cnt <= got_cnt + 8'h01;
		end else if (evt_valid && wait_r >= stall) begin
			evt_ready <= 1'b1;
		end else if (evt_valid) begin
			wait_r <= wait_r + 4'h1;
		end
	end
endmodule

// *** tb/senr_monitor.sv ***
`timescale 1ns/1ps
// ****************************************
// port checker for the error reporting top
// ****************************************
module senr_monitor
import senr_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic [7:0] IO_WDATA,
	input wire logic [7:0] CFG_ADDR,
	input wire logic CFG_WR,
	input wire logic [7:0] CFG_WDATA,
	input wire logic IO_CHANNEL_CHECK_N,
	input wire logic ISA_MEM_PARITY_ERR,
	input wire logic TARGET_ABORT,
	input wire logic SEC_PERR_N,
	input wire logic FORWARD_ENABLE,
	input wire logic SMI_ENABLE,
	input wire logic NMI,
	input wire logic SMI,
	input wire logic PRI_SERR_OE_N,
	input wire logic PRI_PERR_OE_N,
	input wire logic EVT_VALID,
	input wire logic [7:0] EVT_SENSOR_TYPE,
	input wire logic [7:0] EVT_SENSOR_NUM,
	input wire logic [7:0] EVT_TYPE_CODE,
	input wire logic [7:0] EVT_DATA1,
	input wire logic [7:0] EVT_DATA3
);
	logic chk_en_r, par_en_r, mask_r, serr_r, perr_r;
	logic [7:0] ec_r;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// shadows of the enables, taken from the write strobes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			{chk_en_r, par_en_r, mask_r, serr_r, perr_r, ec_r} <= '0;
		end else begin
			if (IO_WR && IO_ADDR == IO_SYSCTL) {chk_en_r, par_en_r} <= IO_WDATA[3:2];
			if (IO_WR && IO_ADDR == IO_NMI_MASK) mask_r <= IO_WDATA[NMI_MASK_BIT];
			if (CFG_WR && CFG_ADDR == CFG_ERR_CMD) ec_r <= CFG_WDATA;
			if (CFG_WR && CFG_ADDR == CFG_SERR_EN) serr_r <= CFG_WDATA[SERR_EN_BIT];
			if (CFG_WR && CFG_ADDR == CFG_PARITY_EN) perr_r <= CFG_WDATA[PERR_EN_BIT];
		end
	end
	// ****************************************
	// interrupt routing
	// ****************************************
	sequence s_chk_held;
		(!IO_CHANNEL_CHECK_N && chk_en_r && !mask_r && !SMI_ENABLE)[*4];
	endsequence
	sequence s_par_smi;
		ISA_MEM_PARITY_ERR && par_en_r && SMI_ENABLE ##1 SMI_ENABLE[*2];
	endsequence
	property p_chk_nmi; s_chk_held |-> NMI; endproperty
	a_chk_nmi: assert property (p_chk_nmi) else $error("no NMI on channel check");
	property p_par_smi; s_par_smi |-> SMI && !NMI; endproperty
	a_par_smi: assert property (p_par_smi) else $error("no SMI on parity error");
	property p_mask; mask_r[*3] |-> !NMI; endproperty
	a_mask: assert property (p_mask) else $error("NMI while masked");
	property p_no_smi; (!SMI_ENABLE)[*3] |-> !SMI; endproperty
	a_no_smi: assert property (p_no_smi) else $error("SMI while disabled");
	property p_smi_first; SMI_ENABLE[*3] |-> !NMI; endproperty
	a_smi_first: assert property (p_smi_first) else $error("NMI while SMI enabled");
	// ****************************************
	// bridge pins and records
	// ****************************************
	property p_ta_serr; TARGET_ABORT && ec_r[EC_TA] && serr_r |=> !PRI_SERR_OE_N; endproperty
	a_ta_serr: assert property (p_ta_serr) else $error("no SERR on target abort");
	property p_fwd; !SEC_PERR_N && FORWARD_ENABLE && perr_r |=> !PRI_PERR_OE_N; endproperty
	a_fwd: assert property (p_fwd) else $error("PERR not forwarded");
	property p_fixed;
		EVT_VALID |-> EVT_SENSOR_NUM == 8'hEF && EVT_TYPE_CODE == 8'hE7 && EVT_SENSOR_TYPE inside {8'h0C, 8'h13};
	endproperty
	a_fixed: assert property (p_fixed) else $error("bad fixed record fields");
	property p_d1; EVT_VALID |-> !EVT_DATA1[7] && !EVT_DATA1[4]; endproperty
	a_d1: assert property (p_d1) else $error("bad first data byte flags");
	property p_mem_d3; EVT_VALID && EVT_SENSOR_TYPE == 8'h0C |-> EVT_DATA3 == 8'hFF; endproperty
	a_mem_d3: assert property (p_mem_d3) else $error("memory record byte three");
endmodule

// *** tb/senr_top_test.sv ***
`timescale 1ns/1ps
module senr_top_test;
import senr_pkg::*;
	logic CLK, RESET_N, IO_WR, IO_RD, CFG_WR, CFG_RD, IO_CHANNEL_CHECK_N, ISA_MEM_PARITY_ERR;
	logic SINGLE_BIT_ERROR, MULTI_BIT_ERROR, TARGET_ABORT, PCI_PARITY_ERR, SEC_SERR_N, SEC_PERR_N;
	logic FORWARD_ENABLE, SMI_ENABLE, NMI, SMI, PRI_SERR_N_O, PRI_SERR_OE_N, PRI_PERR_N_O, PRI_PERR_OE_N;
	logic EVT_VALID, EVT_READY;
	logic [15:0] IO_ADDR;
	logic [7:0] IO_WDATA, IO_RDATA, CFG_ADDR, CFG_WDATA, CFG_RDATA, ISA_SLOT, ECC_DIMM, PCI_ERR_BUS;
	logic [7:0] PCI_ERR_DEVFN, EVT_SENSOR_TYPE, EVT_SENSOR_NUM, EVT_TYPE_CODE, EVT_DATA1, EVT_DATA2;
	logic [7:0] EVT_DATA3, EVT_SW_ID, got_cnt, seen;
	logic [2:0] ECC_ROW;
	logic [3:0] stall;
	logic [55:0] got_rec, r;
	senr_origin_t EVT_ORIGIN;
	int miscompares = 0;
	int comparisons = 0;
	wire serr_wire = PRI_SERR_OE_N ? 1'b1 : PRI_SERR_N_O; // pulled up when released
	wire perr_wire = PRI_PERR_OE_N ? 1'b1 : PRI_PERR_N_O;
	wire [55:0] rec_bus = {EVT_SENSOR_TYPE, EVT_SENSOR_NUM, EVT_TYPE_CODE, EVT_DATA1, EVT_DATA2, EVT_DATA3, EVT_SW_ID};
	senr_top uut (.CLK, .RESET_N, .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA, .IO_RDATA, .CFG_ADDR, .CFG_WR,
		.CFG_RD, .CFG_WDATA, .CFG_RDATA, .IO_CHANNEL_CHECK_N, .ISA_MEM_PARITY_ERR, .ISA_SLOT,
		.SINGLE_BIT_ERROR, .MULTI_BIT_ERROR, .ECC_ROW, .ECC_DIMM, .TARGET_ABORT, .PCI_PARITY_ERR,
		.PCI_ERR_BUS, .PCI_ERR_DEVFN, .SEC_SERR_N, .SEC_PERR_N, .FORWARD_ENABLE, .SMI_ENABLE, .EVT_ORIGIN,
		.NMI, .SMI, .PRI_SERR_N_O, .PRI_SERR_OE_N, .PRI_PERR_N_O, .PRI_PERR_OE_N, .EVT_VALID, .EVT_READY,
		.EVT_SENSOR_TYPE, .EVT_SENSOR_NUM, .EVT_TYPE_CODE, .EVT_DATA1, .EVT_DATA2, .EVT_DATA3, .EVT_SW_ID);
	senr_mgmt_model mc (.CLK, .RESET_N, .stall(stall), .evt_valid(EVT_VALID), .evt_rec(rec_bus),
		.evt_ready(EVT_READY), .got_rec(got_rec), .got_cnt(got_cnt));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	// one strobe cycle on the port or config bus; read data lands at the taking edge
	task automatic bus(input bit cfg, input bit wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge CLK);
		if (cfg) {CFG_ADDR, CFG_WDATA, CFG_WR, CFG_RD} <= {a[7:0], d, wr, !wr};
		else {IO_ADDR, IO_WDATA, IO_WR, IO_RD} <= {a, d, wr, !wr};
		@(posedge CLK);
		{IO_WR, IO_RD, CFG_WR, CFG_RD} <= 4'h0;
		#1 q = cfg ? CFG_RDATA : IO_RDATA;
	endtask
	task automatic wr(input bit cfg, input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(cfg, 1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string n, input bit cfg, input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus(cfg, 1'b0, a, 8'h00, q);
		check(n, exp, q);
	endtask
	task pulse(input int k);
		@(posedge CLK);
		case (k)
			0: SINGLE_BIT_ERROR <= 1'b1;
			1: MULTI_BIT_ERROR <= 1'b1;
			2: ISA_MEM_PARITY_ERR <= 1'b1;
			3: TARGET_ABORT <= 1'b1;
			default: PCI_PARITY_ERR <= 1'b1;
		endcase
		@(posedge CLK);
		{SINGLE_BIT_ERROR, MULTI_BIT_ERROR, ISA_MEM_PARITY_ERR, TARGET_ABORT, PCI_PARITY_ERR} <= 5'h00;
		#1;
	endtask
	// first new record, then quiet time so trailing records are skipped
	task wait_rec();
		for (int i = 0; i < 60 && got_cnt === seen; i++) @(posedge CLK);
		if (got_cnt === seen) begin
			miscompares++;
			$display("[FAIL] record expected arrival seen none");
			tally_and_finish();
		end else begin
			r = got_rec;
			cyc(16);
			seen = got_cnt;
		end
	endtask
	function automatic logic [55:0] rec(input logic [7:0] st, d1, d2, d3, sw);
		return {st, 8'hEF, 8'hE7, d1, d2, d3, sw};
	endfunction
	// ****************************************
	// scenarios
	// ****************************************
	task t_regs();
		logic [7:0] ofs [3] = '{8'h04, 8'h05, 8'h90};
		rd_chk("port61", 0, 16'h0061, 8'h00);
		rd_chk("port62", 0, 16'h0062, 8'h00);
		rd_chk("cfg91", 1, 16'h0091, 8'h00);
		wr(0, 16'h0061, 8'hFF);
		rd_chk("port61 rw", 0, 16'h0061, 8'h0C);
		wr(0, 16'h0061, 8'h00);
		wr(1, 16'h0091, 8'hFF);
		rd_chk("cfg91 ro", 1, 16'h0091, 8'h00);
		foreach (ofs[i]) begin
			rd_chk("cfg reset", 1, ofs[i], 8'h00);
			wr(1, ofs[i], 8'hA5);
			rd_chk("cfg rw", 1, ofs[i], 8'hA5);
			wr(1, ofs[i], 8'h00);
		end
		$display("t_regs done");
	endtask
	task t_io_channel_check_n();
		@(posedge CLK);
		{stall, ISA_SLOT} <= {4'h5, 8'h03};
		wr(0, 16'h0061, 8'h08);
		@(posedge CLK);
		IO_CHANNEL_CHECK_N <= 1'b0;
		cyc(3);
		rd_chk("port61 chk", 0, 16'h0061, 8'h48);
		check("NMI chk", 1, NMI);
		check("SMI chk", 0, SMI);
		wait_rec();
		check("chk record", rec(8'h13, 8'h02, 8'h03, 8'hFF, 8'h00), r);
		wr(0, 16'h0070, 8'h80);
		cyc(3);
		check("NMI masked", 0, NMI);
		wr(0, 16'h0070, 8'h00);
		cyc(3);
		check("NMI unmasked", 1, NMI);
		@(posedge CLK);
		{IO_CHANNEL_CHECK_N, stall} <= {1'b1, 4'h0};
		wr(0, 16'h0061, 8'h00);
		cyc(3);
		check("NMI cleared", 0, NMI);
		$display("t_io_channel_check_n done");
	endtask
	task t_parity();
		@(posedge CLK);
		SMI_ENABLE <= 1'b1;
		wr(0, 16'h0061, 8'h04);
		pulse(2);
		cyc(2);
		check("SMI par", 1, SMI);
		check("NMI par", 0, NMI);
		rd_chk("port61 par", 0, 16'h0061, 8'h84);
		wait_rec();
		check("par record", rec(8'h0C, 8'h02, 8'hFF, 8'hFF, 8'h00), r);
		@(posedge CLK);
		SMI_ENABLE <= 1'b0;
		cyc(3);
		check("NMI no smi", 1, NMI);
		check("SMI off", 0, SMI);
		wr(0, 16'h0061, 8'h00);
		cyc(3);
		check("NMI par clr", 0, NMI);
		$display("t_parity done");
	endtask
	task t_ecc();
		logic [7:0] q;
		logic [7:0] sw [4] = '{8'h00, 8'h10, 8'h01, 8'h11};
		wr(1, 16'h0005, 8'h02);
		wr(1, 16'h0090, 8'h03);
		@(posedge CLK);
		{ECC_ROW, ECC_DIMM} <= {3'h5, 8'h03};
		pulse(0);
		check("serr sbe", 0, serr_wire);
		rd_chk("cfg91 sbe", 1, 16'h0091, 8'h0B);
		wait_rec();
		check("sbe record", rec(8'h0C, 8'h20, 8'h03, 8'hFF, 8'h00), r);
		@(posedge CLK);
		{ECC_ROW, ECC_DIMM} <= {3'h6, 8'h01};
		pulse(1);
		check("serr mbe", 0, serr_wire);
		rd_chk("cfg91 mbe", 1, 16'h0091, 8'hDB);
		wait_rec();
		check("mbe record", rec(8'h0C, 8'h21, 8'h01, 8'hFF, 8'h00), r);
		wr(1, 16'h0091, 8'h11);
		bus(1, 1'b0, 16'h0091, 8'h00, q);
		check("cfg91 flags", 8'h00, q & 8'h11);
		wr(1, 16'h0090, 8'h00);
		pulse(0);
		check("serr sbe off", 1, serr_wire);
		cyc(16);
		seen = got_cnt;
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			EVT_ORIGIN <= senr_origin_t'(i);
			ECC_DIMM <= 8'(i);
			pulse(0);
			wait_rec();
			check("origin", rec(8'h0C, 8'h20, 8'(i), 8'hFF, sw[i]), r);
		end
		$display("t_ecc done");
	endtask
	task t_pci();
		wr(1, 16'h0004, 8'h40);
		wr(1, 16'h0005, 8'h02);
		wr(1, 16'h0090, 8'h18);
		@(posedge CLK);
		{PCI_ERR_BUS, PCI_ERR_DEVFN} <= {8'h07, 8'h4A}; // device 9 function 2
		EVT_ORIGIN <= ORG_POST;
		pulse(4);
		check("serr parity", 0, serr_wire);
		wait_rec();
		check("perr record", rec(8'h13, 8'h44, 8'h07, 8'h4A, 8'h00), r);
		pulse(3);
		check("serr abort", 0, serr_wire);
		wait_rec();
		check("serr record", rec(8'h13, 8'h45, 8'h07, 8'h4A, 8'h00), r);
		@(posedge CLK);
		{FORWARD_ENABLE, SEC_SERR_N, SEC_PERR_N} <= 3'b100;
		cyc(2);
		check("fwd serr", 0, serr_wire);
		check("fwd perr", 0, perr_wire);
		@(posedge CLK);
		FORWARD_ENABLE <= 1'b0;
		cyc(2);
		check("no fwd perr", 1, perr_wire);
		@(posedge CLK);
		{SEC_SERR_N, SEC_PERR_N} <= 2'b11;
		wr(1, 16'h0005, 8'h00);
		pulse(3);
		check("serr gated", 1, serr_wire);
		$display("t_pci done");
	endtask
	// ****************************************
	// clock and main sequence
	// ****************************************
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	initial begin
		{RESET_N, IO_WR, IO_RD, CFG_WR, CFG_RD, ISA_MEM_PARITY_ERR, SINGLE_BIT_ERROR, MULTI_BIT_ERROR} = '0;
		{TARGET_ABORT, PCI_PARITY_ERR, FORWARD_ENABLE, SMI_ENABLE, IO_ADDR, IO_WDATA, CFG_ADDR} = '0;
		{CFG_WDATA, ISA_SLOT, ECC_ROW, ECC_DIMM, PCI_ERR_BUS, PCI_ERR_DEVFN, stall, seen} = '0;
		{IO_CHANNEL_CHECK_N, SEC_SERR_N, SEC_PERR_N} = 3'h7;
		EVT_ORIGIN = ORG_POST;
		repeat (8) @(posedge CLK);
		RESET_N <= 1'b1;
		t_regs();
		t_io_channel_check_n();
		t_parity();
		t_ecc();
		t_pci();
		tally_and_finish();
	end
endmodule
bind senr_top senr_monitor mon (.CLK, .RESET_N, .IO_ADDR, .IO_WR, .IO_WDATA, .CFG_ADDR, .CFG_WR, .CFG_WDATA,
	.IO_CHANNEL_CHECK_N, .ISA_MEM_PARITY_ERR, .TARGET_ABORT, .SEC_PERR_N, .FORWARD_ENABLE, .SMI_ENABLE,
	.NMI, .SMI, .PRI_SERR_OE_N, .PRI_PERR_OE_N, .EVT_VALID, .EVT_SENSOR_TYPE, .EVT_SENSOR_NUM,
	.EVT_TYPE_CODE, .EVT_DATA1, .EVT_DATA3);
